// ---- rtl/trap_status_flags.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// trap status flags with register port and trap interrupt
module trap_status_flags (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // trap sources from the core, same clock, high for each occurrence
    input wire logic arith_error_trap,
    input wire logic address_error_trap,
    input wire logic stack_error_trap,
    input wire logic oscillator_failure_trap,
    // register port
    input wire tsf_pkg::tsf_addr_t reg_addr,
    input wire tsf_pkg::tsf_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tsf_pkg::tsf_data_t reg_rdata,
    // flag levels to the core
    output logic arith_error_flag,
    output logic address_error_flag,
    output logic stack_error_flag,
    output logic oscillator_failure_flag,
    // interrupt
    output logic irq
);

    // ==========================================================
    // trap gathering
    tsf_pkg::tsf_trap_vec_t trap_vec;
    tsf_pkg::tsf_trap_vec_t flag_vec;
    tsf_pkg::tsf_trap_vec_t flag_clr;
    tsf_pkg::tsf_trap_vec_t wr_field;

    // each source lands on its own lane of the trap vector
    assign trap_vec[tsf_pkg::IDX_ARITH_ERR] = arith_error_trap;
    assign trap_vec[tsf_pkg::IDX_ADDR_ERR] = address_error_trap;
    assign trap_vec[tsf_pkg::IDX_STACK_ERR] = stack_error_trap;
    assign trap_vec[tsf_pkg::IDX_OSC_FAIL] = oscillator_failure_trap;

    // ==========================================================
    // register decode
    logic sel_trap;
    logic sel_status;
    logic sel_mask;
    logic wr_trap;
    logic wr_mask;
    logic rd_status;

    assign sel_trap = tsf_pkg::tsf_hit(reg_addr, tsf_pkg::OFF_TRAP_CTRL);
    assign sel_status = tsf_pkg::tsf_hit(reg_addr, tsf_pkg::OFF_IRQ_STATUS);
    assign sel_mask = tsf_pkg::tsf_hit(reg_addr, tsf_pkg::OFF_IRQ_MASK);
    assign wr_trap = reg_wr & sel_trap;
    assign wr_mask = reg_wr & sel_mask;
    assign rd_status = reg_rd & sel_status;

    // writable lanes of the data word, bit 0 and upper bits dropped
    assign wr_field = reg_wdata[tsf_pkg::FLAG_LSB +: tsf_pkg::NUM_TRAPS];

    // only a written zero clears; a written one leaves the flag alone
    assign flag_clr = {tsf_pkg::NUM_TRAPS{wr_trap}} & ~wr_field;

    // ==========================================================
    // sticky trap flags, one instance per trap
    generate
        for (genvar i = 0; i < tsf_pkg::NUM_TRAPS; i++) begin : g_flag
            tsf_sticky_flag u_flag (
                .mclk(mclk),
                .reset_n(reset_n),
                .set(trap_vec[i]),
                .clr(flag_clr[i]),
                .flag(flag_vec[i])
            );
        end
    endgenerate

    // flag levels for the core's trap logic
    assign arith_error_flag = flag_vec[tsf_pkg::IDX_ARITH_ERR];
    assign address_error_flag = flag_vec[tsf_pkg::IDX_ADDR_ERR];
    assign stack_error_flag = flag_vec[tsf_pkg::IDX_STACK_ERR];
    assign oscillator_failure_flag = flag_vec[tsf_pkg::IDX_OSC_FAIL];

    // ==========================================================
    // interrupt unit
    tsf_pkg::tsf_trap_vec_t status_vec;
    tsf_pkg::tsf_trap_vec_t mask_vec;

    tsf_irq_unit u_irq (
        .mclk(mclk),
        .reset_n(reset_n),
        .event_vec(trap_vec),
        .status_rd(rd_status),
        .mask_wr(wr_mask),
        .mask_wdata(wr_field),
        .status_vec(status_vec),
        .mask_vec(mask_vec),
        .irq(irq)
    );

    // ==========================================================
    // read path
    tsf_pkg::tsf_data_t trap_image;
    tsf_pkg::tsf_data_t status_image;
    tsf_pkg::tsf_data_t mask_image;
    tsf_pkg::tsf_data_t rd_mux;
    tsf_pkg::tsf_data_t rdata_q;
    tsf_pkg::tsf_data_t rdata_d;

    // placement puts a zero in bit 0 and in every bit above the flags
    assign trap_image = tsf_pkg::tsf_place(flag_vec);
    assign status_image = tsf_pkg::tsf_place(status_vec);
    assign mask_image = tsf_pkg::tsf_place(mask_vec);

    // unmapped addresses answer zero, so software never sees stale data
    assign rd_mux = sel_trap ? trap_image :
                    sel_status ? status_image :
                    sel_mask ? mask_image : tsf_pkg::READ_ZERO;

    // data stands only in the cycle after the strobe
    assign rdata_d = reg_rd ? rd_mux : tsf_pkg::READ_ZERO;
    assign reg_rdata = rdata_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_q <= tsf_pkg::READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

endmodule // trap_status_flags

`default_nettype wire

// ---- rtl/tsf_pkg.sv ----
`default_nettype none

package tsf_pkg;

    // ==========================================================
    // widths and types
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_TRAPS = 4;

    typedef logic [ADDR_W-1:0] tsf_addr_t;
    typedef logic [DATA_W-1:0] tsf_data_t;
    typedef logic [NUM_TRAPS-1:0] tsf_trap_vec_t;

    // ==========================================================
    // register offsets (byte addresses)
    localparam tsf_addr_t OFF_TRAP_CTRL = 8'h00;
    localparam tsf_addr_t OFF_IRQ_STATUS = 8'h04;
    localparam tsf_addr_t OFF_IRQ_MASK = 8'h08;

    // ==========================================================
    // field positions: trap vector index i sits at bit FLAG_LSB + i
    localparam int FLAG_LSB = 1;
    localparam int IDX_OSC_FAIL = 0;
    localparam int IDX_STACK_ERR = 1;
    localparam int IDX_ADDR_ERR = 2;
    localparam int IDX_ARITH_ERR = 3;
    localparam int BIT_UNIMPL = 0;

    // ==========================================================
    // reset values
    localparam logic FLAG_RESET = 1'b0;
    localparam tsf_data_t READ_ZERO = 16'h0000;
    localparam tsf_trap_vec_t MASK_RESET = 4'h0;

    // register select decode, shared by the read and write paths
    function automatic logic tsf_hit(input tsf_addr_t addr, input tsf_addr_t off);
        tsf_hit = (addr == off);
    endfunction

    // place the trap vector into its register lanes, all other bits zero
    function automatic tsf_data_t tsf_place(input tsf_trap_vec_t v);
        tsf_place = tsf_data_t'(v) << FLAG_LSB;
    endfunction

endpackage

`default_nettype wire

// ---- rtl/tsf_sticky_flag.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// one sticky status bit: set wins over a clear in the same cycle
module tsf_sticky_flag (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // control
    input wire logic set,
    input wire logic clr,
    // state
    output logic flag
);

    logic flag_q;
    logic flag_d;

    // a clear that meets a new event must not drop the event
    assign flag_d = set | (flag_q & ~clr);
    assign flag = flag_q;

    // synchronous reset to the defined idle value
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            flag_q <= tsf_pkg::FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule // tsf_sticky_flag

`default_nettype wire

// ---- rtl/tsf_irq_unit.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// interrupt status (clear on read), mask and level output
module tsf_irq_unit (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // events, one pulse per trap occurrence
    input wire tsf_pkg::tsf_trap_vec_t event_vec,
    // software side
    input wire logic status_rd,
    input wire logic mask_wr,
    input wire tsf_pkg::tsf_trap_vec_t mask_wdata,
    // state
    output tsf_pkg::tsf_trap_vec_t status_vec,
    output tsf_pkg::tsf_trap_vec_t mask_vec,
    output logic irq
);

    tsf_pkg::tsf_trap_vec_t mask_q;
    tsf_pkg::tsf_trap_vec_t mask_d;

    // sticky status bits; the read returns the old value, then clears
    generate
        for (genvar i = 0; i < tsf_pkg::NUM_TRAPS; i++) begin : g_status
            tsf_sticky_flag u_status (
                .mclk(mclk),
                .reset_n(reset_n),
                .set(event_vec[i]),
                .clr(status_rd),
                .flag(status_vec[i])
            );
        end
    endgenerate

    // mask write path
    assign mask_d = mask_wr ? mask_wdata : mask_q;
    assign mask_vec = mask_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mask_q <= tsf_pkg::MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    // level output straight from flops, no extra latency on the request
    assign irq = |(status_vec & mask_q);

endmodule // tsf_irq_unit

`default_nettype wire

// ---- test/tsf_checker_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// port-level checks of the trap flag block
module tsf_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // trap sources
    input wire logic arith_error_trap,
    input wire logic address_error_trap,
    input wire logic stack_error_trap,
    input wire logic oscillator_failure_trap,
    // register port
    input wire tsf_pkg::tsf_addr_t reg_addr,
    input wire tsf_pkg::tsf_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire tsf_pkg::tsf_data_t reg_rdata,
    // flag levels
    input wire logic arith_error_flag,
    input wire logic address_error_flag,
    input wire logic stack_error_flag,
    input wire logic oscillator_failure_flag
);
    // flags in register order, so a read can be tied to the state before it
    wire logic [3:0] flags = {arith_error_flag, address_error_flag,
        stack_error_flag, oscillator_failure_flag};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_ARITH_SET: assert property (arith_error_trap |=> arith_error_flag)
        else $error("arith flag not set after trap");
    AST_ADDR_SET: assert property (address_error_trap |=> address_error_flag)
        else $error("address flag not set after trap");
    AST_STACK_SET: assert property (stack_error_trap |=> stack_error_flag)
        else $error("stack flag not set after trap");
    AST_OSC_SET: assert property (oscillator_failure_trap |=> oscillator_failure_flag)
        else $error("oscillator flag not set after trap");
    AST_BIT0_ZERO: assert property (reg_rdata[0] == 1'b0)
        else $error("bit 0 read as one");
    AST_READ_IMAGE: assert property (reg_rd && reg_addr == 8'h00
        |=> reg_rdata[4:1] == $past(flags))
        else $error("flag read does not match flags");
    AST_FLAG_HOLD: assert property (stack_error_flag
        && !(reg_wr && reg_addr == 8'h00) |=> stack_error_flag)
        else $error("stack flag dropped without a write");
    AST_FLAG_CLEAR: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[1]
        && !oscillator_failure_trap |=> !oscillator_failure_flag)
        else $error("oscillator flag not cleared by write");
    // a flag must never rise without its own trap, or software sees a phantom
    AST_ARITH_QUIET: assert property (!arith_error_flag
        && !arith_error_trap |=> !arith_error_flag)
        else $error("arith flag set without a trap");
    AST_ADDR_QUIET: assert property (!address_error_flag
        && !address_error_trap |=> !address_error_flag)
        else $error("address flag set without a trap");
    AST_STACK_QUIET: assert property (!stack_error_flag
        && !stack_error_trap |=> !stack_error_flag)
        else $error("stack flag set without a trap");
    AST_OSC_QUIET: assert property (!oscillator_failure_flag
        && !oscillator_failure_trap |=> !oscillator_failure_flag)
        else $error("oscillator flag set without a trap");
    // read data stand only in the cycle after a read strobe
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data seen without a read");
endmodule // tsf_checker

bind trap_status_flags tsf_checker i_chk (.mclk, .reset_n, .arith_error_trap,
    .address_error_trap, .stack_error_trap, .oscillator_failure_trap, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .arith_error_flag, .address_error_flag,
    .stack_error_flag, .oscillator_failure_flag);

`default_nettype wire

// ---- test/trap_status_flags_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// self-checking bench for the trap flag block
module trap_status_flags_tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] trap = 4'h0;
    tsf_pkg::tsf_addr_t addr = 8'h00;
    tsf_pkg::tsf_data_t wd = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    tsf_pkg::tsf_data_t rdata;
    logic [3:0] flg;
    logic irq;
    logic [3:0] exp_f;
    logic [3:0] v;
    tsf_pkg::tsf_data_t d;
    tsf_pkg::tsf_addr_t a;
    int err_total = 0;
    int n_compared = 0;
    int i;

    // 20 MHz clock
    always #25 mclk = ~mclk;

    trap_status_flags i_dut (.mclk(mclk), .reset_n(reset_n),
        .arith_error_trap(trap[3]), .address_error_trap(trap[2]),
        .stack_error_trap(trap[1]), .oscillator_failure_trap(trap[0]),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .arith_error_flag(flg[3]), .address_error_flag(flg[2]),
        .stack_error_flag(flg[1]), .oscillator_failure_flag(flg[0]), .irq(irq));

    // register image of a flag vector: bit 0 and upper bits stay zero
    function automatic tsf_pkg::tsf_data_t img(input logic [3:0] f);
        return {11'h000, f, 1'b0};
    endfunction

    task automatic chk(input tsf_pkg::tsf_data_t seen, input tsf_pkg::tsf_data_t exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one-cycle strobes; results are sampled 1 ns after the taking edge
    task automatic wr_reg(input tsf_pkg::tsf_addr_t ad, input tsf_pkg::tsf_data_t dt);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= ad;
        wd <= dt;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input tsf_pkg::tsf_addr_t ad, input tsf_pkg::tsf_data_t e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= ad;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic pulse(input logic [3:0] t);
        @(posedge mclk);
        trap <= t;
        @(posedge mclk);
        trap <= 4'h0;
        #1;
    endtask

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        finish_test();
    end

    initial begin
        void'($urandom(44791));
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        rd_reg(8'h00, 16'h0000);
        rd_reg(8'h08, 16'h0000);
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            pulse(4'h1 << i);
            chk({12'h000, flg}, {12'h000, 4'h1 << i});
            wr_reg(8'h00, 16'hFFFF);
            rd_reg(8'h00, img(4'h1 << i));
            rd_reg(8'h04, img(4'h1 << i));
            rd_reg(8'h04, 16'h0000);
            wr_reg(8'h00, 16'h0000);
            rd_reg(8'h00, 16'h0000);
        end
        $display("single trap test done");
        // only the stack event is unmasked
        wr_reg(8'h08, 16'h0004);
        pulse(4'h4);
        chk({15'h0000, irq}, 16'h0000);
        pulse(4'h2);
        chk({15'h0000, irq}, 16'h0001);
        rd_reg(8'h04, img(4'h6));
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(8'h08, 16'h0004);
        $display("interrupt test done");
        // trap and write-zero in one cycle: the trap must win
        @(posedge mclk);
        trap <= 4'hF;
        wr <= 1'b1;
        addr <= 8'h00;
        wd <= 16'h0000;
        @(posedge mclk);
        trap <= 4'h0;
        wr <= 1'b0;
        #1 chk({12'h000, flg}, 16'h000F);
        $display("set wins test done");
        exp_f = 4'hF;
        for (i = 0; i < 40; i++) begin
            v = 4'($urandom);
            d = 16'($urandom);
            a = ($urandom & 1) ? 8'h0C : 8'h00;
            pulse(v);
            exp_f |= v;
            wr_reg(a, d);
            if (a == 8'h00) exp_f &= d[4:1];
            rd_reg(8'h00, img(exp_f));
            rd_reg(8'h0C, 16'h0000);
        end
        $display("random test done");
        // a reset in mid-run drops every flag and the mask
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd_reg(8'h00, 16'h0000);
        rd_reg(8'h08, 16'h0000);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule // trap_status_flags_tb

`default_nettype wire
